// ---- hdl/key_store_consts.svh ----
// Offsets, field positions, codes and the unmapped-read marker for the key store.
// Assumes inclusion by bare name from files under hdl/.
`ifndef KEY_STORE_CONSTS_SVH
`define KEY_STORE_CONSTS_SVH

// ============================================================
// Register map (word-aligned byte addresses)
`define KS_REG_CTRL 8'h00
`define KS_REG_STATUS 8'h04
`define KS_REG_SELECT 8'h08
`define KS_REG_KEY0 8'h10
`define KS_REG_KEY1 8'h14
`define KS_REG_KEY2 8'h18
`define KS_REG_KEY3 8'h1c
`define KS_REG_ACCESS 8'h20
`define KS_REG_PART 8'h24

// ============================================================
// Field layouts
`define KS_IDX_SET_BIT 3
`define KS_NUM_ENTRIES 8
`define KS_KEY_BITS 128
`define KS_ACCESS_RIGHTS_BIT 4
`define KS_SEL_CIPHER_BIT 18

// Command codes written to CTRL[3:0].
`define KS_CMD_NONE 4'h0
`define KS_CMD_LOOKUP_AUTH 4'h1
`define KS_CMD_LOOKUP_CIPHER 4'h2
`define KS_CMD_WRITE_MANUAL 4'h3
`define KS_CMD_ALLOCATE 4'h4
`define KS_CMD_AUTH_DONE 4'h5
`define KS_CMD_ERASE 4'h6

// Key kind codes carried in the 4-bit type fields.
`define KS_AUTH_USER_KEY 4'h1
`define KS_AUTH_ACTIVATION 4'h2
`define KS_AUTH_USER_KEY_PIN 4'h3
`define KS_CIPH_DERIVED 4'h1
`define KS_CIPH_STATIC 4'h2
`define KS_CIPH_DEFAULT 4'h3

`define KS_BUS_UNMAPPED 32'hdeadbeef

`endif

// ---- hdl/key_store_pkg.sv ----
// Types shared by the key store.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package key_store_pkg;
  typedef enum logic [2:0] {
    KIND_USER_KEY = 3'b000,
    KIND_ACTIVATION = 3'b001,
    KIND_DERIVED = 3'b010,
    KIND_STATIC = 3'b011,
    KIND_DEFAULT = 3'b100,
    KIND_NONE = 3'b111
  } key_kind_e;
endpackage
`default_nettype wire

// ---- hdl/key_bank.sv ----
// One bank of key entries with valid bits, indexed by set and number.
// Assumes the parent serialises accesses; one write per cycle.
`default_nettype none
module key_bank #(
  parameter int KEY_BITS = 128,
  parameter int ENTRIES = 16
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] rd_idx_i,
  output logic [KEY_BITS-1:0] rd_key_o,
  output logic rd_valid_o,
  input wire logic wr_en_i,
  input wire logic erase_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [KEY_BITS-1:0] wr_key_i
);
  // Key contents are not reset: they model the non-volatile array.
  logic [KEY_BITS-1:0] mem_q [ENTRIES];
  logic [ENTRIES-1:0] valid_q;

  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_idx_i] <= wr_key_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      valid_q <= '0;
    end else if (wr_en_i) begin
      valid_q[wr_idx_i] <= 1'b1;
    end else if (erase_i) begin
      valid_q[wr_idx_i] <= 1'b0;
    end
  end

  assign rd_key_o = mem_q[rd_idx_i];
  assign rd_valid_o = valid_q[rd_idx_i];
endmodule
`default_nettype wire

// ---- hdl/key_store.sv ----
// Key store and key-number decoder for the handset security unit.
// Assumes an Avalon-MM master on ref_clk_i; all inputs synchronous.
`include "key_store_consts.svh"
`default_nettype none

module key_store #(
  parameter int KEY_BITS = `KS_KEY_BITS,
  parameter int SESSION_BYTES = 8
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [KEY_BITS-1:0] user_personal_identity_i,
  output logic [KEY_BITS-1:0] key_o,
  output logic key_valid_o,
  output logic key_not_available_o
);
  // Each bank holds both sets of eight; index bit 3 picks the identity set or the pair set.
  localparam int ENTRIES = 2 * `KS_NUM_ENTRIES;
  localparam int SESSION_BITS = SESSION_BYTES * 8;

  // ============================================================
  // Helpers
  // Byte-lane merge, so a partial write keeps the lanes it does not enable.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Expand the session key cyclically to the user key width.
  function automatic logic [KEY_BITS-1:0] expand(input logic [SESSION_BITS-1:0] ks);
    logic [KEY_BITS-1:0] r;
    r = '0;
    for (int i = 0; i < KEY_BITS / 8; i++) begin
      r[i*8 +: 8] = ks[(i % SESSION_BYTES)*8 +: 8];
    end
    return r;
  endfunction

  // ============================================================
  // Software-visible state
  logic [3:0] cmd_q;
  logic [31:0] select_q;
  logic [31:0] key_q [4];
  logic roaming_q;
  logic busy_q;
  logic done_q;
  logic reject_q;
  logic [KEY_BITS-1:0] key_out_q;
  logic key_valid_q;
  logic nak_q;

  // select_q fields:
  // [3:0] key kind, [7:4] key index, [11:8] destination user key index,
  // [15:12] default index, [16] store-derived flag, [17] default flag.
  // [18] cipher space for manual writes and erases.
  logic [3:0] sel_kind;
  logic [3:0] sel_idx;
  logic [3:0] sel_dst;
  logic [3:0] sel_def;
  logic store_derived_key_flag;
  logic default_key_flag;
  assign sel_kind = select_q[3:0];
  assign sel_idx = select_q[7:4];
  assign sel_dst = select_q[11:8];
  assign sel_def = select_q[15:12];
  assign store_derived_key_flag = select_q[16];
  assign default_key_flag = select_q[17];

  // KEY0 holds bits 31:0 of the source key.
  logic [KEY_BITS-1:0] key_word;
  assign key_word = {key_q[3], key_q[2], key_q[1], key_q[0]};

  // ============================================================
  // Kind decode
  // The same 4-bit kind code names different banks in the two key spaces, so the
  // command, and for manual writes and erases one select bit, picks the space.
  function automatic key_store_pkg::key_kind_e auth_bank(input logic [3:0] kind);
    case (kind)
      `KS_AUTH_USER_KEY: return key_store_pkg::KIND_USER_KEY;
      // The combined kind reaches the user key entry only.
      `KS_AUTH_USER_KEY_PIN: return key_store_pkg::KIND_USER_KEY;
      `KS_AUTH_ACTIVATION: return key_store_pkg::KIND_ACTIVATION;
      default: return key_store_pkg::KIND_NONE;
    endcase
  endfunction

  function automatic key_store_pkg::key_kind_e cipher_bank(input logic [3:0] kind);
    case (kind)
      `KS_CIPH_DERIVED: return key_store_pkg::KIND_DERIVED;
      `KS_CIPH_STATIC: return key_store_pkg::KIND_STATIC;
      `KS_CIPH_DEFAULT: return key_store_pkg::KIND_DEFAULT;
      default: return key_store_pkg::KIND_NONE;
    endcase
  endfunction

  logic manual_cmd;
  logic auth_space;
  assign manual_cmd = cmd_q == `KS_CMD_WRITE_MANUAL || cmd_q == `KS_CMD_ERASE;
  assign auth_space = cmd_q == `KS_CMD_LOOKUP_AUTH || cmd_q == `KS_CMD_ALLOCATE ||
    (manual_cmd && !select_q[`KS_SEL_CIPHER_BIT]);

  key_store_pkg::key_kind_e bank_sel;
  always_comb begin
    if (auth_space) begin
      bank_sel = auth_bank(sel_kind);
    end else begin
      bank_sel = cipher_bank(sel_kind);
    end
  end

  // ============================================================
  // Banks: user key, activation code, derived, static, default.
  // Bank order follows key_kind_e, so the decoded kind indexes the enables directly.
  logic [4:0] wr_en;
  logic [4:0] erase;
  logic [3:0] wr_idx [5];
  logic [KEY_BITS-1:0] wr_key [5];
  logic [3:0] rd_idx [5];
  logic [KEY_BITS-1:0] rd_key [5];
  logic [4:0] rd_valid;

  for (genvar g = 0; g < 5; g++) begin : g_bank
    key_bank #(
      .KEY_BITS(KEY_BITS),
      .ENTRIES(ENTRIES)
    ) u_bank (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .rd_idx_i(rd_idx[g]),
      .rd_key_o(rd_key[g]),
      .rd_valid_o(rd_valid[g]),
      .wr_en_i(wr_en[g]),
      .erase_i(erase[g]),
      .wr_idx_i(wr_idx[g]),
      .wr_key_i(wr_key[g])
    );
  end

  // Allocation is acceptable only with the activation code present and no roaming.
  // A refused allocation leaves both banks untouched, so the code can be used later.
  logic alloc_ok;
  assign alloc_ok = rd_valid[1] && !roaming_q;

  always_comb begin
    wr_en = '0;
    erase = '0;
    for (int b = 0; b < 5; b++) begin
      wr_idx[b] = sel_idx;
      wr_key[b] = key_word;
      rd_idx[b] = sel_idx;
    end
    if (busy_q) begin
      case (cmd_q)
        `KS_CMD_WRITE_MANUAL: begin
          // Activation codes and static keys are loaded only this way.
          // The select space bit decides whether a user key or activation bank or a cipher key bank is loaded.
          if (bank_sel != key_store_pkg::KIND_NONE) begin
            wr_en[bank_sel] = 1'b1;
          end
        end
        `KS_CMD_ERASE: begin
          // Erasing only drops the valid bit; the stale key bits stay but can no longer be read.
          if (bank_sel != key_store_pkg::KIND_NONE) begin
            erase[bank_sel] = 1'b1;
          end
        end
        `KS_CMD_ALLOCATE: begin
          if (alloc_ok) begin
            wr_en[0] = 1'b1;
            wr_idx[0] = sel_dst;
            wr_key[0] = expand(key_word[SESSION_BITS-1:0]);
            erase[1] = 1'b1;
          end
        end
        `KS_CMD_AUTH_DONE: begin
          // Derived key overwrites its index; default key overwrites its own.
          wr_en[2] = store_derived_key_flag;
          wr_en[4] = default_key_flag;
          wr_idx[4] = sel_def;
          rd_idx[4] = sel_def;
        end
        default: begin
        end
      endcase
    end
  end

  // ============================================================
  // Command sequencing
  // A command is taken only while idle. It runs during the single busy cycle
  // that follows, so two commands never overlap, and the source key words and
  // the selection word cannot change under it: register writes are held off
  // by waitrequest for that cycle. Every command completes in that one cycle,
  // so no counter is needed.
  logic start;
  assign start = avs_write_i && !busy_q && avs_address_i == `KS_REG_CTRL && avs_byteenable_i[0];

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_q <= `KS_CMD_NONE;
      busy_q <= 1'b0;
    end else if (start) begin
      cmd_q <= avs_writedata_i[3:0];
      busy_q <= avs_writedata_i[3:0] != `KS_CMD_NONE;
    end else begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      key_out_q <= '0;
      key_valid_q <= 1'b0;
      nak_q <= 1'b0;
      done_q <= 1'b0;
      reject_q <= 1'b0;
    end else if (start) begin
      key_valid_q <= 1'b0;
      nak_q <= 1'b0;
      done_q <= 1'b0;
      reject_q <= 1'b0;
    end else if (busy_q) begin
      done_q <= 1'b1;
      // Flags stand until the next command clears them, the key until the next lookup; a result register, not a live
      // bank read, keeps the key still while software walks KEY0..KEY3.
      case (cmd_q)
        `KS_CMD_LOOKUP_AUTH, `KS_CMD_LOOKUP_CIPHER: begin
          if (bank_sel != key_store_pkg::KIND_NONE && rd_valid[bank_sel]) begin
            key_valid_q <= 1'b1;
            // The personal identity is only mixed in on the fly, never kept.
            key_out_q <= (sel_kind == `KS_AUTH_USER_KEY_PIN && cmd_q == `KS_CMD_LOOKUP_AUTH) ?
              rd_key[bank_sel] ^ user_personal_identity_i : rd_key[bank_sel];
          end else begin
            nak_q <= 1'b1;
            key_out_q <= '0;
          end
        end
        `KS_CMD_ALLOCATE: reject_q <= !alloc_ok;
        default: begin
        end
      endcase
    end
  end

  // ============================================================
  // Register writes
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      select_q <= '0;
      roaming_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        key_q[i] <= '0;
      end
    end else if (avs_write_i && !busy_q) begin
      case (avs_address_i)
        `KS_REG_SELECT: select_q <= merge(select_q, avs_writedata_i, avs_byteenable_i);
        `KS_REG_KEY0: key_q[0] <= merge(key_q[0], avs_writedata_i, avs_byteenable_i);
        `KS_REG_KEY1: key_q[1] <= merge(key_q[1], avs_writedata_i, avs_byteenable_i);
        `KS_REG_KEY2: key_q[2] <= merge(key_q[2], avs_writedata_i, avs_byteenable_i);
        `KS_REG_KEY3: key_q[3] <= merge(key_q[3], avs_writedata_i, avs_byteenable_i);
        // The roaming flag stands until software clears it; while set, allocation is refused.
        `KS_REG_ACCESS: begin
          if (avs_byteenable_i[0]) begin
            roaming_q <= avs_writedata_i[0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ============================================================
  // Bus reads; one wait cycle while a command executes.
  // Read map: CTRL returns the last command, STATUS the flags
  // {alloc_reject, not_available, key_valid, done, busy} from bit 4 down,
  // SELECT the selection word, KEY0..KEY3 the last lookup result with KEY0
  // holding bits 31:0, and ACCESS the roaming flag. Anything else reads a
  // fixed marker so that a stray address is easy to spot.
  // Reads wait too while a command runs; only that raises waitrequest, and then
  // for exactly one cycle. Writes in that cycle are stalled, not dropped.
  assign avs_waitrequest_o = busy_q;

  logic [31:0] status_word;
  assign status_word = {27'h0, reject_q, nak_q, key_valid_q, done_q, busy_q};

  always_comb begin
    case (avs_address_i)
      `KS_REG_CTRL: avs_readdata_o = {28'h0000000, cmd_q};
      `KS_REG_STATUS: avs_readdata_o = status_word;
      `KS_REG_SELECT: avs_readdata_o = select_q;
      `KS_REG_KEY0: avs_readdata_o = key_out_q[31:0];
      `KS_REG_KEY1: avs_readdata_o = key_out_q[63:32];
      `KS_REG_KEY2: avs_readdata_o = key_out_q[95:64];
      `KS_REG_KEY3: avs_readdata_o = key_out_q[127:96];
      `KS_REG_ACCESS: avs_readdata_o = {31'h0, roaming_q};
      default: avs_readdata_o = `KS_BUS_UNMAPPED;
    endcase
  end

  assign key_o = key_out_q;
  assign key_valid_o = key_valid_q;
  assign key_not_available_o = nak_q;
endmodule
`default_nettype wire

// ---- tb/key_store_chk_sva.sv ----
// Checker for the key store bus handshake and lookup result ports.
// Assumes binding into key_store and the shared constants header on the include path.
`include "key_store_consts.svh"
`default_nettype none
module key_store_chk #(
  parameter int KEY_BITS = 128
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [KEY_BITS-1:0] key_o,
  input wire logic key_valid_o,
  input wire logic key_not_available_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ============================================================
  // Helpers
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic cmd_go;
  assign cmd_go = avs_write_i && !avs_waitrequest_o && avs_address_i == `KS_REG_CTRL && avs_byteenable_i[0]
                  && avs_writedata_i[3:0] != 4'h0;
  sequence s_cmd;
    cmd_go;
  endsequence
  sequence s_busy;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  // ============================================================
  // Properties
  property p_busy_pulse;
    s_cmd |=> s_busy;
  endproperty
  a_busy_pulse: assert property (p_busy_pulse) else $error("busy pulse not one cycle after command");
  property p_busy_cause;
    $rose(avs_waitrequest_o) |-> $past(cmd_go);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
  property p_flags_excl;
    !(key_valid_o && key_not_available_o);
  endproperty
  a_flags_excl: assert property (p_flags_excl) else $error("hit and miss together");
  property p_miss_zero;
    key_not_available_o |-> key_o == '0;
  endproperty
  a_miss_zero: assert property (p_miss_zero) else $error("key data on a miss");
  property p_hold;
    $changed(key_o) || $changed(key_valid_o) |-> $past(cmd_go) || $past(cmd_go, 2);
  endproperty
  a_hold: assert property (p_hold) else $error("lookup result moved without command");
  property p_unmapped;
    avs_read_i && avs_address_i == `KS_REG_PART |-> avs_readdata_o == `KS_BUS_UNMAPPED;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read value wrong");
  property p_status;
    avs_read_i && !avs_waitrequest_o && avs_address_i == `KS_REG_STATUS
      |-> avs_readdata_o[3:2] == {key_not_available_o, key_valid_o};
  endproperty
  a_status: assert property (p_status) else $error("status flags differ from ports");
  property p_key_read;
    avs_read_i && !avs_waitrequest_o && avs_address_i == `KS_REG_KEY0 |-> avs_readdata_o == key_o[31:0];
  endproperty
  a_key_read: assert property (p_key_read) else $error("key word differs from key port");
endmodule
bind key_store key_store_chk #(.KEY_BITS(KEY_BITS)) u_chk (.ref_clk_i, .resetn_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .key_o, .key_valid_o,
  .key_not_available_o);
`default_nettype wire

// ---- tb/fixed_side_model.sv ----
// Model of the fixed side: supplies the personal identity value for each use.
// Assumes one clock; the value means something only while use_i is high.
`default_nettype none
module fixed_side_model (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic use_i,
  input wire logic [127:0] seed_i,
  output logic [127:0] identity_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [127:0] noise_q;
  // Outside a use the value churns every cycle, so a copy kept inside the store would show.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) noise_q <= '0;
    else noise_q <= ~noise_q ^ {noise_q[126:0], 1'b1};
  end
  assign identity_o = use_i ? seed_i : noise_q;
endmodule
`default_nettype wire

// ---- tb/tb_security_key_store_indexing.sv ----
// Self-checking bench for the key store: lookups, allocation and cipher key saves.
// Assumes the checker is bound to the store and the fixed side model drives the identity.
`include "key_store_consts.svh"
`default_nettype none
module tb_security_key_store_indexing;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, resetn_i, rd, wr, id_use, kv, kna, wait_o;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, got;
  logic [127:0] ident, key, id_seed;
  int num_errors = 0;
  int checks_done = 0;
  key_store dut (.ref_clk_i, .resetn_i, .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
    .user_personal_identity_i(ident), .key_o(key), .key_valid_o(kv), .key_not_available_o(kna));
  fixed_side_model partner (.ref_clk_i, .resetn_i, .use_i(id_use), .seed_i(id_seed), .identity_o(ident));
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // ============================================================
  // Common tasks
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [127:0] g, input logic [127:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wait_o !== 1'b0 && n < 20);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (wait_o !== 1'b0) begin
      num_errors++;
      end_of_test();
    end
  endtask
  // Field packing of the selection word.
  function automatic logic [31:0] sel(input logic [3:0] kind, idx, dest, dix, input logic st, df);
    return {14'h0, df, st, dix, dest, idx, kind};
  endfunction
  function automatic logic [127:0] mk(input logic [31:0] s);
    return {s, ~s, s ^ 32'h5a5a5a5a, s + 32'h1};
  endfunction
  task automatic load(input logic [127:0] k);
    for (int i = 0; i < 4; i++) bus(1'b1, `KS_REG_KEY0 + 8'(4 * i), k[32 * i +: 32]);
  endtask
  task automatic cmd(input logic [31:0] s, input logic [3:0] c);
    bus(1'b1, `KS_REG_SELECT, s);
    bus(1'b1, `KS_REG_CTRL, {28'h0, c});
    bus(1'b0, `KS_REG_STATUS, 32'h0);
  endtask
  task automatic put(input logic [3:0] kind, idx, input logic [127:0] k);
    load(k);
    cmd(sel(kind, idx, 4'h0, 4'h0, 1'b0, 1'b0), `KS_CMD_WRITE_MANUAL);
  endtask
  task automatic look(input logic ciph, input logic [3:0] kind, idx, input logic hit, input logic [127:0] e);
    cmd(sel(kind, idx, 4'h0, 4'h0, 1'b0, 1'b0), ciph ? `KS_CMD_LOOKUP_CIPHER : `KS_CMD_LOOKUP_AUTH);
    @(negedge ref_clk_i);
    cmp(kv, hit);
    cmp(kna, !hit);
    cmp(key, hit ? e : 128'h0);
  endtask
  task automatic saved(input logic [127:0] k, input logic [31:0] s);
    load(k);
    cmd(s, `KS_CMD_AUTH_DONE);
  endtask
  // ============================================================
  // Scenarios
  task automatic t_reset();
    cmp(kv, 1'b0);
    cmp(kna, 1'b0);
    bus(1'b0, `KS_REG_PART, 32'h0);
    cmp(got, `KS_BUS_UNMAPPED);
    look(1'b0, `KS_AUTH_USER_KEY, 4'h0, 1'b0, 128'h0);
    $display("reset test done");
  endtask
  task automatic t_auth_keys();
    put(`KS_AUTH_USER_KEY, 4'h0, mk(32'h10));
    put(`KS_AUTH_USER_KEY, 4'h8, mk(32'h20));
    put(`KS_AUTH_USER_KEY, 4'h7, mk(32'h30));
    look(1'b0, `KS_AUTH_USER_KEY, 4'h0, 1'b1, mk(32'h10));
    look(1'b0, `KS_AUTH_USER_KEY, 4'h8, 1'b1, mk(32'h20));
    look(1'b0, `KS_AUTH_USER_KEY, 4'h7, 1'b1, mk(32'h30));
    bus(1'b0, `KS_REG_KEY0, 32'h0);
    cmp(got, mk(32'h30) & 128'hffffffff);
    cmd(sel(`KS_AUTH_USER_KEY, 4'h7, 4'h0, 4'h0, 1'b0, 1'b0), `KS_CMD_ERASE);
    look(1'b0, `KS_AUTH_USER_KEY, 4'h7, 1'b0, 128'h0);
    look(1'b0, `KS_AUTH_USER_KEY, 4'hf, 1'b0, 128'h0);
    look(1'b0, `KS_AUTH_ACTIVATION, 4'h0, 1'b0, 128'h0);
    $display("auth key test done");
  endtask
  task automatic t_identity();
    @(posedge ref_clk_i);
    id_use <= 1'b1;
    id_seed <= mk(32'h77);
    look(1'b0, `KS_AUTH_USER_KEY_PIN, 4'h8, 1'b1, mk(32'h20) ^ mk(32'h77));
    @(posedge ref_clk_i);
    id_seed <= mk(32'h99);
    look(1'b0, `KS_AUTH_USER_KEY_PIN, 4'h8, 1'b1, mk(32'h20) ^ mk(32'h99));
    @(posedge ref_clk_i);
    id_use <= 1'b0;
    look(1'b0, `KS_AUTH_USER_KEY, 4'h8, 1'b1, mk(32'h20));
    $display("identity test done");
  endtask
  task automatic t_alloc();
    logic [31:0] s;
    logic [127:0] ks;
    s = sel(`KS_AUTH_ACTIVATION, 4'h9, 4'h3, 4'h0, 1'b0, 1'b0);
    ks = mk(32'h55);
    load(mk(32'h55));
    cmd(s, `KS_CMD_ALLOCATE);
    cmp(got[4], 1'b1);
    look(1'b0, `KS_AUTH_USER_KEY, 4'h3, 1'b0, 128'h0);
    put(`KS_AUTH_ACTIVATION, 4'h9, mk(32'hac));
    bus(1'b1, `KS_REG_ACCESS, 32'h1);
    load(mk(32'h55));
    cmd(s, `KS_CMD_ALLOCATE);
    cmp(got[4], 1'b1);
    look(1'b0, `KS_AUTH_ACTIVATION, 4'h9, 1'b1, mk(32'hac));
    bus(1'b1, `KS_REG_ACCESS, 32'h0);
    load(mk(32'h55));
    cmd(s, `KS_CMD_ALLOCATE);
    cmp(got[4], 1'b0);
    look(1'b0, `KS_AUTH_USER_KEY, 4'h3, 1'b1, {2{ks[63:0]}});
    look(1'b0, `KS_AUTH_ACTIVATION, 4'h9, 1'b0, 128'h0);
    $display("allocation test done");
  endtask
  task automatic t_cipher();
    saved(mk(32'hd1), sel(4'h0, 4'h1, 4'h0, 4'h0, 1'b0, 1'b0));
    look(1'b1, `KS_CIPH_DERIVED, 4'h1, 1'b0, 128'h0);
    saved(mk(32'hd1), sel(4'h0, 4'h1, 4'h0, 4'h0, 1'b1, 1'b0));
    look(1'b1, `KS_CIPH_DERIVED, 4'h1, 1'b1, mk(32'hd1));
    saved(mk(32'hd2), sel(4'h0, 4'h1, 4'h0, 4'h0, 1'b1, 1'b0));
    look(1'b1, `KS_CIPH_DERIVED, 4'h1, 1'b1, mk(32'hd2));
    look(1'b1, `KS_CIPH_DERIVED, 4'h9, 1'b0, 128'h0);
    saved(mk(32'hd3), sel(4'h0, 4'h1, 4'h0, 4'h2, 1'b0, 1'b1));
    look(1'b1, `KS_CIPH_DEFAULT, 4'h2, 1'b1, mk(32'hd3));
    look(1'b1, `KS_CIPH_DERIVED, 4'h1, 1'b1, mk(32'hd2));
    saved(mk(32'hd4), sel(4'h0, 4'h1, 4'h0, 4'h2, 1'b0, 1'b1));
    look(1'b1, `KS_CIPH_DEFAULT, 4'h2, 1'b1, mk(32'hd4));
    load(mk(32'h5c));
    cmd(sel(`KS_CIPH_STATIC, 4'h5, 4'h0, 4'h0, 1'b0, 1'b0) | (32'h1 << `KS_SEL_CIPHER_BIT), `KS_CMD_WRITE_MANUAL);
    look(1'b1, `KS_CIPH_STATIC, 4'h5, 1'b1, mk(32'h5c));
    look(1'b0, `KS_AUTH_ACTIVATION, 4'h5, 1'b0, 128'h0);
    $display("cipher test done");
  endtask
  // ============================================================
  // Main sequence
  initial begin
    resetn_i = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    id_use = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    id_seed = 128'h0;
    repeat (6) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_auth_keys();
    t_identity();
    t_alloc();
    t_cipher();
    end_of_test();
  end
endmodule
`default_nettype wire
